// File: inc/uatx_map.vh
// register map, field positions, reset values and widths of the async transmitter
// assumes a 32-bit classic wishbone slave port with word-aligned registers
`ifndef UATX_MAP_VH
`define UATX_MAP_VH

// ************************************************************
// register byte offsets
// ************************************************************
`define UATX_ADDR_W 4
`define UATX_OFF_CTRL 4'h0
`define UATX_OFF_STAT 4'h4
`define UATX_OFF_DATA 4'h8
`define UATX_OFF_BAUD 4'hc

// ************************************************************
// control register fields
// ************************************************************
`define UATX_CTL_TX_ENABLE 0
`define UATX_CTL_PORT_ENABLE 1
`define UATX_CTL_CLOCKED_MODE 2
`define UATX_CTL_NINE_BIT 3
`define UATX_CTL_INVERT 4
`define UATX_CTL_IRQ_ENABLE 5
`define UATX_CTL_NINTH_BIT 6
`define UATX_CTL_WIDE_DIV 7
`define UATX_CTL_HIGH_SPEED 8
`define UATX_CTL_W 9
`define UATX_CTL_RST 9'h000

// ************************************************************
// status register fields
// ************************************************************
`define UATX_STA_BUF_EMPTY 0
`define UATX_STA_SHIFT_EMPTY 1

// ************************************************************
// baud divisor and prescale counts
// ************************************************************
`define UATX_DIV_W 16
`define UATX_DIV_RST 16'h0000
`define UATX_PRE_X4 6'h03
`define UATX_PRE_X16 6'h0f
`define UATX_PRE_X64 6'h3f

// ************************************************************
// character format
// ************************************************************
`define UATX_CHAR_W 9
`define UATX_BITS_8 4'h8
`define UATX_BITS_9 4'h9

`endif

// File: test/test_uart_async_transmitter.sv
// self-checking bench: character rows through one loop, then edge cases
// assumes uatx_line_rx on the line and uatx_props bound to uatx_top
`timescale 1ns/1ps
`include "uatx_map.vh"

module test_uart_async_transmitter;
	logic core_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, inv, nine;
	logic [3:0] wb_adr_i, wb_sel_i;
	logic [31:0] wb_dat_i, rd;
	logic [32:0] rows [0:5];
	logic [9:0] got_q[$];
	int at_q[$], run_q[$];
	int bit_clk, err_count, samples_checked, cyc_n, i, lo_n;
	wire [31:0] wb_dat_o;
	wire [8:0] rx_char;
	wire wb_ack_o, tx_pin_out, tx_pin_oe, tx_irq_req, rx_stop, rx_stb;

	uatx_top dut (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_pin_out(tx_pin_out), .tx_pin_oe(tx_pin_oe),
		.tx_logic_cell(), .tx_irq_req(tx_irq_req), .shared_bit_tick(), .shared_nine_bit_sel());
	uatx_line_rx u_rx (.core_clk(core_clk), .line(tx_pin_out), .inv(inv), .nine(nine),
		.bit_clk(bit_clk), .rx_char(rx_char), .rx_stop(rx_stop), .rx_stb(rx_stb));

	// 25 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end
	// cycle count, received frames and lengths of space runs on the line
	always @(posedge core_clk)
	begin
		cyc_n <= cyc_n + 1;
		if (tx_pin_out === inv)
			lo_n <= lo_n + 1;
		else
		begin
			if (lo_n != 0)
				run_q.push_back(lo_n);
			lo_n <= 0;
		end
		if (rx_stb === 1'b1)
		begin
			got_q.push_back({rx_stop, rx_char});
			at_q.push_back(cyc_n);
		end
	end
	// watchdog
	initial
	begin
		repeat (30000) @(posedge core_clk);
		err_count++;
		final_report();
	end

	// ************************************************************
	// bus, compare and frame tasks
	// ************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wb(input logic we, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do
		begin
			@(posedge core_clk);
			n++;
		end
		while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1)
		begin
			err_count++;
			$display("wrong value at %0t: no bus acknowledge", $time);
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task rchk(input logic [3:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	function int per(input logic [8:0] c, input logic [15:0] dv);
		int p;
		p = (c[7] && c[8]) ? 4 : (c[7] || c[8]) ? 16 : 64;
		return p * ((c[7] ? int'(dv) : int'(dv[7:0])) + 1);
	endfunction
	task setup(input logic [8:0] c, input logic [15:0] dv);
		wb(1'b1, `UATX_OFF_BAUD, {16'h0000, dv});
		wb(1'b1, `UATX_OFF_CTRL, {23'h0, c});
		repeat (2) @(posedge core_clk);
		inv <= c[4];
		nine <= c[3];
		bit_clk <= per(c, dv);
		repeat (70) @(posedge core_clk);
	endtask
	task wait_rx(input int k);
		int n;
		n = 0;
		while (got_q.size() < k && n < 3000)
		begin
			@(posedge core_clk);
			n++;
		end
		if (got_q.size() < k)
		begin
			err_count++;
			$display("wrong value at %0t: frame not received", $time);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// ************************************************************
	// main sequence
	// ************************************************************
	initial
	begin
		rst_b = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i, inv, nine} = 5'h00;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'hf;
		wb_dat_i = 32'h0;
		bit_clk = 4;
		rows[0] = {9'h183, 16'h0000, 8'ha5};
		rows[1] = {9'h1cb, 16'h0002, 8'h3c};
		rows[2] = {9'h093, 16'h0001, 8'hc3};
		rows[3] = {9'h15b, 16'h0000, 8'h81};
		rows[4] = {9'h10b, 16'h0101, 8'h7e};
		rows[5] = {9'h003, 16'h0000, 8'h5a};
		repeat (16) @(posedge core_clk);
		rst_b <= 1'b1;
		rchk(`UATX_OFF_CTRL, 32'h0);
		rchk(`UATX_OFF_BAUD, 32'h0);
		rchk(`UATX_OFF_STAT, 32'h2);
		rchk(4'h2, 32'h0);
		for (i = 0; i < 6; i++)
		begin
			setup(rows[i][32:24], rows[i][23:8]);
			wb(1'b1, `UATX_OFF_DATA, {24'h0, rows[i][7:0]});
			wait_rx(1);
			chk(got_q.pop_front(), {1'b1, rows[i][27] & rows[i][30], rows[i][7:0]});
			void'(at_q.pop_front());
			repeat (bit_clk) @(posedge core_clk);
		end
		// queued character follows the stop bit with no gap
		setup(9'h1a3, 16'h0000);
		chk(tx_irq_req, 1'b1);
		run_q.delete();
		wb(1'b1, `UATX_OFF_DATA, 32'h11);
		wb(1'b1, `UATX_OFF_DATA, 32'h22);
		rchk(`UATX_OFF_STAT, 32'h0);
		chk(tx_irq_req, 1'b0);
		wb(1'b1, `UATX_OFF_STAT, 32'h3);
		rchk(`UATX_OFF_STAT, 32'h0);
		wait_rx(2);
		chk(got_q[0], 10'h211);
		chk(run_q[0], bit_clk);
		chk(got_q[1], 10'h222);
		chk(at_q[1] - at_q[0], 40);
		repeat (8) @(posedge core_clk);
		rchk(`UATX_OFF_STAT, 32'h3);
		// abandon a character in flight
		wb(1'b1, `UATX_OFF_DATA, 32'h0f);
		repeat (12) @(posedge core_clk);
		wb(1'b1, `UATX_OFF_CTRL, 32'h182);
		repeat (2) @(posedge core_clk);
		chk(tx_pin_out, 1'b1);
		rchk(`UATX_OFF_STAT, 32'h2);
		repeat (60) @(posedge core_clk);
		got_q.delete();
		// clocked mode keeps the async path quiet
		wb(1'b1, `UATX_OFF_CTRL, 32'h1a7);
		wb(1'b1, `UATX_OFF_DATA, 32'h55);
		repeat (60) @(posedge core_clk);
		chk(got_q.size(), 0);
		rchk(`UATX_OFF_STAT, 32'h3);
		// reset in mid-frame
		wb(1'b1, `UATX_OFF_CTRL, 32'h183);
		wb(1'b1, `UATX_OFF_DATA, 32'h5a);
		repeat (10) @(posedge core_clk);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk({tx_pin_out, tx_pin_oe}, 2'b10);
		rst_b <= 1'b1;
		rchk(`UATX_OFF_CTRL, 32'h0);
		final_report();
	end
endmodule // test_uart_async_transmitter

// File: test/uatx_line_rx.sv
// remote receiver model: confirms start at mid-bit, samples each bit at its middle
// assumes the bench gives bit length in core_clk cycles, format and polarity
`timescale 1ns/1ps

module uatx_line_rx (
	// clock and line
	input wire core_clk,
	input wire line,
	// format from the bench
	input wire inv,
	input wire nine,
	input wire [31:0] bit_clk,
	// received frame
	output logic [8:0] rx_char,
	output logic rx_stop,
	output logic rx_stb
);
	logic lv;
	int i;
	assign lv = line ^ inv; // undo polarity
	// frame receiver, one frame per start
	initial
	begin
		rx_char = 9'h000;
		rx_stop = 1'b0;
		rx_stb = 1'b0;
		forever
		begin
			@(posedge core_clk);
			rx_stb <= 1'b0;
			if (lv === 1'b0)
			begin
				repeat (bit_clk / 2) @(posedge core_clk);
				if (lv === 1'b0)
				begin
					rx_char = 9'h000;
					for (i = 0; i < (nine ? 9 : 8); i++)
					begin
						repeat (bit_clk) @(posedge core_clk);
						rx_char[i] = lv;
					end
					repeat (bit_clk) @(posedge core_clk);
					rx_stop <= lv;
					rx_stb <= 1'b1;
				end
			end
		end
	end
endmodule // uatx_line_rx

// File: test/uatx_props.sv
// checker: bus, line and flag relations seen at the transmitter top ports
// assumes one core_clk domain with async active-low rst_b
`timescale 1ns/1ps
`include "uatx_map.vh"

module uatx_props (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	// line and status
	input wire tx_pin_out,
	input wire tx_pin_oe,
	input wire tx_logic_cell,
	input wire tx_irq_req,
	input wire shared_bit_tick,
	input wire shared_nine_bit_sel
);
	logic [8:0] ctl_r;
	logic act;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// transmitter active from the shadow control bits
	assign act = ctl_r[0] && ctl_r[1] && !ctl_r[2];
	// shadow of the control register, written at the ack edge
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			ctl_r <= 9'h000;
		else if (wb_ack_o && wb_we_i && wb_adr_i == `UATX_OFF_CTRL)
		begin
			if (wb_sel_i[0])
				ctl_r[7:0] <= wb_dat_i[7:0];
			if (wb_sel_i[1])
				ctl_r[8] <= wb_dat_i[8];
		end
	end
	a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("no ack one cycle after request");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_cell_copy: assert property (tx_logic_cell == tx_pin_out)
		else $error("logic cell copy differs from pin");
	a_oe_port: assert property (tx_pin_oe == ctl_r[1])
		else $error("pin enable differs from port enable");
	a_nine_share: assert property (shared_nine_bit_sel == ctl_r[3])
		else $error("shared nine bit select wrong");
	a_irq_gate: assert property (tx_irq_req |-> ctl_r[5] && ctl_r[0])
		else $error("irq without enable");
	a_irq_on_enable: assert property ($rose(ctl_r[0]) && ctl_r[5] |-> ##[0:1] tx_irq_req)
		else $error("buffer empty not set on enable");
	a_idle_level: assert property ((!act && $stable(ctl_r)) [*2] |->
		tx_pin_out == !(ctl_r[4] && !ctl_r[2]))
		else $error("line not idle while inactive");
	a_tick_pulse: assert property (shared_bit_tick |=> !shared_bit_tick)
		else $error("bit tick longer than one cycle");
	c_start: cover property ($fell(tx_pin_out));
	c_irq: cover property (tx_irq_req);
	c_enable: cover property ($rose(act));
endmodule // uatx_props

bind uatx_top uatx_props u_props (.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .tx_pin_out(tx_pin_out),
	.tx_pin_oe(tx_pin_oe), .tx_logic_cell(tx_logic_cell), .tx_irq_req(tx_irq_req),
	.shared_bit_tick(shared_bit_tick), .shared_nine_bit_sel(shared_nine_bit_sel));

// File: verilog/uatx_baud.v
// baud rate generator: prescaler of 4, 16 or 64 system clocks, then an 8/16-bit divider
// assumes divisor and speed selects are stable while a character is in flight
`timescale 1ns/1ps
`include "uatx_map.vh"

module uatx_baud #(
	parameter DIV_W = `UATX_DIV_W
) (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// control
	input wire run,
	input wire restart,
	input wire wide_divider_sel,
	input wire high_speed_baud_sel,
	input wire [DIV_W-1:0] divisor,
	// bit-period tick
	output reg bit_tick_r
);

	reg [5:0] pre_cnt_r;
	reg [DIV_W-1:0] div_cnt_r;
	reg [5:0] pre_max;
	reg [DIV_W-1:0] div_max;
	wire pre_end;

	// multiplier and divider width from the two speed selects
	always @*
	begin
		if (wide_divider_sel && high_speed_baud_sel)
			pre_max = `UATX_PRE_X4;
		else if (wide_divider_sel || high_speed_baud_sel)
			pre_max = `UATX_PRE_X16;
		else
			pre_max = `UATX_PRE_X64;
		div_max = wide_divider_sel ? divisor : {{(DIV_W-8){1'b0}}, divisor[7:0]};
	end

	assign pre_end = (pre_cnt_r == pre_max);

	// counters restart so a lone start bit lasts one whole period
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pre_cnt_r <= 6'h00;
			div_cnt_r <= {DIV_W{1'b0}};
			bit_tick_r <= 1'b0;
		end
		else if (!run)
		begin
			pre_cnt_r <= 6'h00;
			div_cnt_r <= {DIV_W{1'b0}};
			bit_tick_r <= 1'b0;
		end
		// restart one count ahead: the start level reaches the pin a cycle late
		else if (restart)
		begin
			pre_cnt_r <= 6'h01;
			div_cnt_r <= {DIV_W{1'b0}};
			bit_tick_r <= 1'b0;
		end
		else
		begin
			bit_tick_r <= 1'b0;
			pre_cnt_r <= pre_end ? 6'h00 : pre_cnt_r + 6'h01;
			if (pre_end)
			begin
				if (div_cnt_r >= div_max)
				begin
					div_cnt_r <= {DIV_W{1'b0}};
					bit_tick_r <= 1'b1;
				end
				else
					div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
			end
		end
	end

endmodule // uatx_baud

// File: verilog/uatx_shreg.v
// transmit shift register: parallel load, lsb-first shift, fills with mark
// assumes the caller decides framing and when to shift
`timescale 1ns/1ps

module uatx_shreg #(
	parameter W = 9
) (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// control
	input wire clear,
	input wire load,
	input wire shift,
	input wire [W-1:0] load_data,
	// serial bit
	output wire lsb
);

	reg [W-1:0] sh_r;

	assign lsb = sh_r[0];

	// lsb goes out first, ones shift in from the top
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			sh_r <= {W{1'b1}};
		else if (clear)
			sh_r <= {W{1'b1}};
		else if (load)
			sh_r <= load_data;
		else if (shift)
			sh_r <= {1'b1, sh_r[W-1:1]};
	end

endmodule // uatx_shreg

// File: verilog/uatx_top.v
// asynchronous nrz transmitter with one-deep holding register and wishbone registers
// assumes a classic wishbone master on core_clk; tx pin routing done outside
//
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "uatx_map.vh"

module uatx_top #(
	parameter DIV_W = `UATX_DIV_W
) (
	// clock and reset
	input wire core_clk,
	input wire rst_b,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [`UATX_ADDR_W-1:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// transmit pin
	output reg tx_pin_out,
	output wire tx_pin_oe,
	// internal serial copy and interrupt request
	output wire tx_logic_cell,
	output wire tx_irq_req,
	// format and baud shared with the receive path
	output wire shared_bit_tick,
	output wire shared_nine_bit_sel
);

	// ************************************************************
	// state codes
	// ************************************************************
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_START = 4'b0010;
	localparam [3:0] ST_DATA = 4'b0100;
	localparam [3:0] ST_STOP = 4'b1000;

	// ************************************************************
	// declarations
	// ************************************************************
	reg [`UATX_CTL_W-1:0] ctrl_r;
	reg [DIV_W-1:0] baud_div_r;
	reg [`UATX_CHAR_W-1:0] hold_data_r;
	reg hold_full_r;
	reg [3:0] state_r;
	reg [3:0] state_nxt;
	reg [3:0] bit_cnt_r;
	reg [3:0] bit_cnt_nxt;
	reg line_nxt;
	reg take_hold;
	reg [31:0] rd_nxt;
	wire bus_req;
	wire wr_stb;
	wire tx_enable;
	wire port_enable;
	wire clocked_mode_sel;
	wire nine_bit_tx_sel;
	wire tx_invert;
	wire tx_irq_enable;
	wire tx_ninth_bit;
	wire tx_active;
	wire bit_tick;
	wire sh_lsb;
	wire [3:0] char_bits;
	wire tx_buffer_empty_flag;
	wire shifter_empty_flag;
	wire baud_restart;

	// ************************************************************
	// control field decode
	// ************************************************************
	assign tx_enable = ctrl_r[`UATX_CTL_TX_ENABLE];
	assign port_enable = ctrl_r[`UATX_CTL_PORT_ENABLE];
	assign clocked_mode_sel = ctrl_r[`UATX_CTL_CLOCKED_MODE];
	assign nine_bit_tx_sel = ctrl_r[`UATX_CTL_NINE_BIT];
	assign tx_invert = ctrl_r[`UATX_CTL_INVERT];
	assign tx_irq_enable = ctrl_r[`UATX_CTL_IRQ_ENABLE];
	assign tx_ninth_bit = ctrl_r[`UATX_CTL_NINTH_BIT];

	// all three conditions needed, else everything is flushed
	assign tx_active = tx_enable && port_enable && !clocked_mode_sel;
	assign char_bits = nine_bit_tx_sel ? `UATX_BITS_9 : `UATX_BITS_8;

	// ************************************************************
	// wishbone slave
	// ************************************************************
	assign bus_req = wb_cyc_i && wb_stb_i;
	// write acts on the edge where ack is sampled high
	assign wr_stb = bus_req && wb_we_i && wb_ack_o;

	// one wait state answer, ack drops the cycle after it was given
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wb_ack_o <= 1'b0;
		else
			wb_ack_o <= bus_req && !wb_ack_o;
	end

	// read mux; flags are computed, writes to status are ignored
	always @*
	begin
		rd_nxt = 32'h0000_0000;
		case (wb_adr_i)
			`UATX_OFF_CTRL:
				rd_nxt[`UATX_CTL_W-1:0] = ctrl_r;
			`UATX_OFF_STAT:
			begin
				rd_nxt[`UATX_STA_BUF_EMPTY] = tx_buffer_empty_flag;
				rd_nxt[`UATX_STA_SHIFT_EMPTY] = shifter_empty_flag;
			end
			`UATX_OFF_DATA:
				rd_nxt[`UATX_CHAR_W-1:0] = hold_data_r;
			`UATX_OFF_BAUD:
				rd_nxt[DIV_W-1:0] = baud_div_r;
			default:
				rd_nxt = 32'h0000_0000;
		endcase
	end

	// read data registered with the ack
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			wb_dat_o <= 32'h0000_0000;
		else if (bus_req && !wb_ack_o)
			wb_dat_o <= rd_nxt;
	end

	// control and divisor registers, byte lanes honoured
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ctrl_r <= `UATX_CTL_RST;
			baud_div_r <= `UATX_DIV_RST;
		end
		else if (wr_stb)
		begin
			if (wb_adr_i == `UATX_OFF_CTRL)
			begin
				if (wb_sel_i[0])
					ctrl_r[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					ctrl_r[8] <= wb_dat_i[8];
			end
			if (wb_adr_i == `UATX_OFF_BAUD)
			begin
				if (wb_sel_i[0])
					baud_div_r[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					baud_div_r[DIV_W-1:8] <= wb_dat_i[DIV_W-1:8];
			end
		end
	end

	// ************************************************************
	// holding register
	// ************************************************************
	// new write beats a same-cycle move into the shifter
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			hold_full_r <= 1'b0;
			hold_data_r <= {`UATX_CHAR_W{1'b0}};
		end
		else if (!tx_active)
			hold_full_r <= 1'b0;
		else if (wr_stb && wb_adr_i == `UATX_OFF_DATA && wb_sel_i[0])
		begin
			hold_full_r <= 1'b1;
			hold_data_r <= {tx_ninth_bit, wb_dat_i[7:0]};
		end
		else if (take_hold)
			hold_full_r <= 1'b0;
	end

	// ************************************************************
	// status and interrupt request
	// ************************************************************
	// flag from tx_enable and holding state; set in the same cycle as enable
	assign tx_buffer_empty_flag = tx_enable && !hold_full_r;
	assign tx_irq_req = tx_buffer_empty_flag && tx_irq_enable;
	// shifter empty is status only, never an interrupt source
	assign shifter_empty_flag = (state_r == ST_IDLE);

	// ************************************************************
	// baud generator and shifter
	// ************************************************************
	// restart only when leaving idle so the first start bit is whole
	assign baud_restart = take_hold && (state_r == ST_IDLE);

	uatx_baud #(
		.DIV_W(DIV_W)
	) u_baud (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.run(tx_active),
		.restart(baud_restart),
		.wide_divider_sel(ctrl_r[`UATX_CTL_WIDE_DIV]),
		.high_speed_baud_sel(ctrl_r[`UATX_CTL_HIGH_SPEED]),
		.divisor(baud_div_r),
		.bit_tick_r(bit_tick)
	);

	// same tick and format offered to the receive side
	assign shared_bit_tick = bit_tick;
	assign shared_nine_bit_sel = nine_bit_tx_sel;

	// data bits only, no parity is ever generated
	uatx_shreg #(
		.W(`UATX_CHAR_W)
	) u_shreg (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clear(!tx_active),
		.load(take_hold),
		.shift(bit_tick && state_r == ST_DATA),
		.load_data(hold_data_r),
		.lsb(sh_lsb)
	);

	// ************************************************************
	// frame sequencer
	// ************************************************************
	always @*
	begin
		state_nxt = state_r;
		bit_cnt_nxt = bit_cnt_r;
		take_hold = 1'b0;
		line_nxt = 1'b1;
		case (state_r)
			ST_IDLE:
			begin
				if (hold_full_r)
				begin
					take_hold = 1'b1;
					state_nxt = ST_START;
				end
			end
			ST_START:
			begin
				line_nxt = 1'b0;
				if (bit_tick)
				begin
					state_nxt = ST_DATA;
					bit_cnt_nxt = 4'h0;
				end
			end
			ST_DATA:
			begin
				line_nxt = sh_lsb;
				if (bit_tick)
				begin
					bit_cnt_nxt = bit_cnt_r + 4'h1;
					if (bit_cnt_r + 4'h1 == char_bits)
						state_nxt = ST_STOP;
				end
			end
			ST_STOP:
			begin
				line_nxt = 1'b1;
				if (bit_tick)
				begin
					if (hold_full_r)
					begin
						take_hold = 1'b1;
						state_nxt = ST_START;
					end
					else
						state_nxt = ST_IDLE;
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// sequencer state; losing enable drops the character
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
		end
		else if (!tx_active)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
		end
		else
		begin
			state_r <= state_nxt;
			bit_cnt_r <= bit_cnt_nxt;
		end
	end

	// ************************************************************
	// line output
	// ************************************************************
	// registered line; mark when idle, inverted only in async mode
	always @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			tx_pin_out <= 1'b1;
		else if (!tx_active)
			tx_pin_out <= !(tx_invert && !clocked_mode_sel);
		else if (state_nxt == ST_IDLE)
			tx_pin_out <= !tx_invert;
		else
			tx_pin_out <= line_nxt ^ tx_invert;
	end

	// pin driven whenever the port is enabled
	assign tx_pin_oe = port_enable;
	assign tx_logic_cell = tx_pin_out;

endmodule // uatx_top
